// ---- bus_cycle_sequencer_io_block_tb.sv ----
// Self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
`include "bus_seq_defs.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module bus_cycle_sequencer_io_block_tb;
  localparam [5:0] S_F1 = 6'h14, S_F2 = 6'h15, S_RD = 6'h17;
  localparam [5:0] S_MW = 6'h27, S_IW = 6'h2B;
  reg         clk_sys = 1'b0;
  reg         rst_n = 1'b0;
  reg         cmd_valid = 1'b0;
  reg  [3:0]  cmd_op = 4'h0;
  reg  [15:0] cmd_pc = 16'h0000, cmd_hl = 16'h0000;
  reg  [15:0] cmd_de = 16'h0000, cmd_bc = 16'h0000;
  reg  [7:0]  cmd_acc = 8'h00, cmd_g = 8'h00;
  reg         rd_ready = 1'b1;
  wire        cmd_ready, data_oe_q, halt_n, rd_valid;
  wire        read_strobe_n, store_strobe_n, memory_request_n;
  wire        io_request_n, opcode_fetch_flag_n, opening_fetch_flag;
  wire [15:0] addr_q;
  wire [7:0]  data_in, data_out_q, rd_data;
  reg  [15:0] pc, hl, de, bc, stp;
  reg  [7:0]  acc, g, x, y;
  reg  [3:0]  pend = 4'h0, opc;
  reg         gap_on = 1'b1, rnd = 1'b0, stall = 1'b0;
  reg  [33:0] cyc_q[$];
  reg  [7:0]  rd_q[$];
  integer     failures = 0, n_checks = 0, seed = 11139, r, q, n;
  always #50 clk_sys = ~clk_sys;
  bus_seq bus_seq_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_pc(cmd_pc),
    .cmd_hl(cmd_hl), .cmd_de(cmd_de), .cmd_bc(cmd_bc), .cmd_acc(cmd_acc),
    .cmd_g(cmd_g), .addr_q(addr_q), .data_in(data_in),
    .data_out_q(data_out_q), .data_oe_q(data_oe_q),
    .read_strobe_n(read_strobe_n), .store_strobe_n(store_strobe_n),
    .memory_request_n(memory_request_n), .io_request_n(io_request_n),
    .opcode_fetch_flag_n(opcode_fetch_flag_n),
    .opening_fetch_flag(opening_fetch_flag), .halt_n(halt_n),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  bus_mem_model bus_mem_model_i (.clk_sys(clk_sys), .addr_q(addr_q),
    .read_strobe_n(read_strobe_n), .data_in(data_in));
  function [7:0] pat(input [15:0] a);
    pat = a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  // Note one bus cycle: strobes, address, data and idle clocks before it
  task cyc(input [5:0] s, input [15:0] a, input [7:0] d);
    begin
      cyc_q.push_back({s, a, d, gap_on ? pend : 4'hF});
      if (!s[5])
        rd_q.push_back(d);
      pend = 4'h0;
    end
  endtask
  task predict(input [3:0] op);
    reg more;
    begin
      stp = (op == `OP_COPY_DN_RPT || op[3] && op[0]) ? 16'hFFFF : 16'h1;
      more = 1'b1;
      while (more) begin
        more = 1'b0;
        cyc(S_F1, pc, pat(pc));
        if (op != `OP_IDLE && op != `OP_PORT_IMM_ACC)
          cyc(S_F2, pc + 16'h1, pat(pc + 16'h1));
        if (op == `OP_MULTIPLY)
          pend = 4'd11;
        if (op == `OP_COPY_UP_RPT || op == `OP_COPY_DN_RPT) begin
          cyc(S_RD, hl, pat(hl));
          cyc(S_MW, de, pat(hl));
          hl = hl + stp;
          de = de + stp;
          bc = bc - 16'h1;
          more = bc != 16'h0;
          pend = more ? 4'd2 : 4'd0;
        end
        if (op == `OP_PORT_IMM_ACC || op == `OP_PAGE0_WRITE) begin
          x = pat(pc + {15'h0, op[1]} + 16'h1);
          cyc(S_RD, pc + {15'h0, op[1]} + 16'h1, x);
          pend = 4'd1;
          if (op[1])
            cyc(S_IW, {`PAGE0_HIGH, x}, g);
          else
            cyc(S_IW, {acc, x}, acc);
        end
        if (op == `OP_PORT_BC_REG) begin
          pend = 4'd1;
          cyc(S_IW, bc, g);
        end
        if (op[3]) begin
          pend = {3'h0, !op[2]};
          x = pat(hl);
          cyc(S_RD, hl, x);
          // The port address carries the count as it stood before the read
          cyc(S_IW, op[2] ? bc : {8'h00, bc[7:0]}, x);
          hl = hl + stp;
          bc = {bc[15:8] - 8'h1, bc[7:0] + (op[2] ? 8'h0 : stp[7:0])};
          more = op[1] && bc[15:8] != 8'h0;
          pend = more ? (op[2] ? 4'd2 : 4'd3) : {3'h0, !op[2]};
        end
      end
    end
  endtask
  task issue(input [3:0] op);
    begin
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_pc = pc;
      cmd_hl = hl;
      cmd_de = de;
      cmd_bc = bc;
      cmd_acc = acc;
      cmd_g = g;
      predict(op);
      while (cmd_ready !== 1'b1)
        @(negedge clk_sys);
      @(posedge clk_sys);
    end
  endtask
  task finish_test(input [8*8-1:0] nm);
    begin
      issue(`OP_IDLE);
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      for (n = 0; n < 4000 && cyc_q.size() + rd_q.size() > 0; n++)
        @(negedge clk_sys);
      `CHK("leftover", 0, cyc_q.size() + rd_q.size())
      $display("test %0s done", nm);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin : watch
    reg [33:0] e;
    reg [3:0]  gap;
    gap = 4'h0;
    forever begin
      @(negedge clk_sys);
      if (rst_n && (!read_strobe_n || !store_strobe_n)) begin
        e = cyc_q.size() ? cyc_q.pop_front() : 34'h0;
        `CHK("strobes", e[33:28], {read_strobe_n, store_strobe_n,
          memory_request_n, io_request_n, opcode_fetch_flag_n,
          opening_fetch_flag})
        `CHK("addr", e[27:12], addr_q)
        `CHK("data", e[11:4], store_strobe_n ? data_in : data_out_q)
        if (e[3:0] != 4'hF)
          `CHK("gap", e[3:0], gap)
        gap = 4'h0;
        repeat (2) @(negedge clk_sys);
      end else if (rst_n && !cmd_ready)
        gap = gap + 4'h1;
    end
  end
  // Ready is set first so the check sees what the next edge will pop
  always @(negedge clk_sys) begin
    q = $random(seed);
    rd_ready = !stall && (!rnd || q[0]);
    if (rst_n && rd_valid === 1'b1 && rd_ready) begin
      y = rd_q.size() ? rd_q.pop_front() : 8'hXX;
      `CHK("rd_data", y, rd_data)
    end
  end
  initial begin
    #(100 * 60000);
    failures++;
    $display("watchdog expired");
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    `CHK("reset", 3'b101, {cmd_ready, rd_valid, halt_n})
    acc = 8'h5A;
    g = 8'hC3;
    for (n = 0; n < 16; n++) begin
      pc = 16'h1000 + 16'h10 * n;
      hl = 16'h2000;
      de = 16'h3000;
      bc = n < 5 ? 16'h0002 : 16'h0203;
      issue(n[3:0]);
    end
    finish_test("directed");
    gap_on = 1'b0;
    rnd = 1'b1;
    for (n = 0; n < 40; n++) begin
      r = $random(seed);
      opc = r[27:24];
      pc = r[15:0];
      hl = r[31:16];
      de = ~r[15:0];
      acc = r[23:16];
      g = r[7:0];
      bc = (opc == `OP_COPY_UP_RPT || opc == `OP_COPY_DN_RPT) ?
        {14'h0, r[29:28]} + 16'h1 : {8'h01 + r[29:28], r[7:0]};
      issue(opc);
    end
    finish_test("random");
    rnd = 1'b0;
    stall = 1'b1;
    pc = 16'h4000;
    hl = 16'h5000;
    de = 16'h6000;
    bc = 16'h0001;
    issue(`OP_COPY_UP_RPT);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    repeat (30) @(negedge clk_sys);
    // Two fetch bytes fill the buffer, so the memory read must wait
    `CHK("paused", 2, cyc_q.size())
    stall = 1'b0;
    finish_test("stall");
    end_of_test;
  end
endmodule // bus_cycle_sequencer_io_block_tb

// ---- bus_mem_model.sv ----
// Behavioural memory answering bus reads
`timescale 1ns/1ps
module bus_mem_model (
  input  wire        clk_sys,
  input  wire [15:0] addr_q,
  input  wire        read_strobe_n,
  output reg  [7:0]  data_in
);
  reg [7:0] last_q = 8'h00;
  // Released bus shows the inverse of the last byte, never a stale copy
  always @*
    data_in = read_strobe_n ? ~last_q : addr_q[7:0] ^ addr_q[15:8] ^ 8'hA5;
  always @(posedge clk_sys)
    if (!read_strobe_n)
      last_q <= data_in;
endmodule // bus_mem_model

// ---- bus_seq.v ----
// Machine-cycle sequencer for the external memory and I/O bus
`timescale 1ns/1ps
`include "bus_seq_defs.vh"

// Function
// - Every instruction opens with a three-state first opcode fetch.
// - Second opcode fetch matches the first but raises opening_fetch_flag.
// - Block copy reads at HL then writes at DE after two fetches.
// - Block copy adds two idle states when the pair count stays nonzero.
// - Block copy ends right after the write when the pair count is zero.
// - Multiply runs two fetches then eleven idle machine cycles.
// - Negate is only the first and second opcode fetches.
// - The idle instruction is one opcode fetch alone.
// - Accumulator port output: fetch, operand, idle, write port and accumulator.
// - Register output to BC: two fetches, idle, I/O write at BC.
// - Page-zero port write: fetches, operand, idle, write with high byte zero.
// - Port block once: fetches, idle, read HL, write C page zero, idle.
// - Repeating port block ends with three idle states when B nonzero.
// - Repeating port block ends with one idle state when B is zero.
// - Port copy: two fetches, read HL, I/O write at BC, no idle.
// - Repeating port copy appends two idle states when B is nonzero.
// - Halt stays high; memory and I/O writes assert the store strobe and their own request.
module bus_seq (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [3:0]  cmd_op,
  input  wire [15:0] cmd_pc,
  input  wire [15:0] cmd_hl,
  input  wire [15:0] cmd_de,
  input  wire [15:0] cmd_bc,
  input  wire [7:0]  cmd_acc,
  input  wire [7:0]  cmd_g,
  output reg  [15:0] addr_q,
  input  wire [7:0]  data_in,
  output reg  [7:0]  data_out_q,
  output reg         data_oe_q,
  output reg         read_strobe_n,
  output reg         store_strobe_n,
  output reg         memory_request_n,
  output reg         io_request_n,
  output reg         opcode_fetch_flag_n,
  output reg         opening_fetch_flag,
  output reg         halt_n,
  output wire        rd_valid,
  input  wire        rd_ready,
  output wire [7:0]  rd_data
);

  localparam [5:0] WAIT_CMD   = 6'h01;
  localparam [5:0] BUS_T1     = 6'h02;
  localparam [5:0] BUS_T2     = 6'h04;
  localparam [5:0] BUS_T3     = 6'h08;
  localparam [5:0] IDLE_STATE = 6'h10;
  localparam [5:0] HOLD_FIFO  = 6'h20;

  reg  [5:0]  st_q;
  reg  [3:0]  op_q;
  reg  [3:0]  step_q;
  reg  [2:0]  kind_q;
  reg  [15:0] pc_q;
  reg  [15:0] hl_q;
  reg  [15:0] de_q;
  reg  [15:0] bc_q;
  reg  [7:0]  acc_q;
  reg  [7:0]  g_q;
  reg  [7:0]  port_q;
  reg  [7:0]  byte_q;

  // Two-entry read data buffer
  reg  [7:0]  buf_mem [0:1];
  reg         wp_q;
  reg         rp_q;
  reg  [1:0]  cnt_q;
  reg  [1:0]  cnt_d;
  wire        push;
  wire        pop;

  wire        start;
  wire        at_end;
  wire        go;
  reg  [3:0]  nstep;
  wire [3:0]  op_src;
  wire        nz;
  wire        rpt;
  reg  [2:0]  nk;
  reg  [3:0]  eff_step;
  reg  [2:0]  eff_kind;
  wire        is_rd;
  wire [7:0]  wr_byte;

  // Kind of machine cycle at a step of an instruction
  function [2:0] step_kind;
    input [3:0] op;
    input [3:0] s;
    input       cnt_nz;
    begin
      if (s == 4'h0) begin
        step_kind = `K_FETCH1;
      end else begin
        step_kind = `K_END;
        case (op)
          `OP_IDLE: begin
            step_kind = `K_END;
          end
          `OP_NEGATE: begin
            if (s == 4'h1)
              step_kind = `K_FETCH2;
          end
          `OP_MULTIPLY: begin
            if (s == 4'h1)
              step_kind = `K_FETCH2;
            else if (s <= `MULT_LAST_STEP)
              step_kind = `K_IDLE;
          end
          `OP_COPY_UP_RPT, `OP_COPY_DN_RPT: begin
            case (s)
              4'h1: step_kind = `K_FETCH2;
              4'h2: step_kind = `K_MEMRD;
              4'h3: step_kind = `K_MEMWR;
              4'h4, 4'h5: step_kind = cnt_nz ? `K_IDLE : `K_END;
              default: step_kind = `K_END;
            endcase
          end
          `OP_PORT_IMM_ACC: begin
            case (s)
              4'h1: step_kind = `K_OPRD;
              4'h2: step_kind = `K_IDLE;
              4'h3: step_kind = `K_IOWR;
              default: step_kind = `K_END;
            endcase
          end
          `OP_PORT_BC_REG: begin
            case (s)
              4'h1: step_kind = `K_FETCH2;
              4'h2: step_kind = `K_IDLE;
              4'h3: step_kind = `K_IOWR;
              default: step_kind = `K_END;
            endcase
          end
          `OP_PAGE0_WRITE: begin
            case (s)
              4'h1: step_kind = `K_FETCH2;
              4'h2: step_kind = `K_OPRD;
              4'h3: step_kind = `K_IDLE;
              4'h4: step_kind = `K_IOWR;
              default: step_kind = `K_END;
            endcase
          end
          `OP_PBLK_INC, `OP_PBLK_DEC,
          `OP_PBLK_INC_RPT, `OP_PBLK_DEC_RPT: begin
            case (s)
              4'h1: step_kind = `K_FETCH2;
              4'h2: step_kind = `K_IDLE;
              4'h3: step_kind = `K_MEMRD;
              4'h4: step_kind = `K_IOWR;
              4'h5: step_kind = `K_IDLE;
              4'h6, 4'h7: step_kind = (op[1] && cnt_nz) ?
                                      `K_IDLE : `K_END;
              default: step_kind = `K_END;
            endcase
          end
          default: begin
            case (s)
              4'h1: step_kind = `K_FETCH2;
              4'h2: step_kind = `K_MEMRD;
              4'h3: step_kind = `K_IOWR;
              4'h4, 4'h5: step_kind = (op[1] && cnt_nz) ?
                                      `K_IDLE : `K_END;
              default: step_kind = `K_END;
            endcase
          end
        endcase
      end
    end
  endfunction

  assign cmd_ready = (st_q == WAIT_CMD);
  assign start     = cmd_ready & cmd_valid;
  assign at_end    = (st_q == BUS_T3) | (st_q == IDLE_STATE);
  assign go        = start | at_end | (st_q == HOLD_FIFO);
  assign op_src    = start ? cmd_op : op_q;

  // Block copy counts the whole pair; port forms count the high byte
  assign nz  = ((op_q == `OP_COPY_UP_RPT) || (op_q == `OP_COPY_DN_RPT)) ?
               (bc_q != 16'h0000) : (bc_q[15:8] != 8'h00);
  assign rpt = (op_q == `OP_COPY_UP_RPT) || (op_q == `OP_COPY_DN_RPT) ||
               (op_q == `OP_PBLK_INC_RPT) || (op_q == `OP_PBLK_DEC_RPT) ||
               (op_q == `OP_PCOPY_INC_RPT) || (op_q == `OP_PCOPY_DEC_RPT);

  always @* begin
    if (start)
      nstep = 4'h0;
    else if (st_q == HOLD_FIFO)
      nstep = step_q;
    else
      nstep = step_q + 4'h1;
    nk = step_kind(op_src, nstep, nz);
    if (nk == `K_END && !start && rpt && nz) begin
      eff_step = 4'h0;
      eff_kind = `K_FETCH1;
    end else begin
      eff_step = nstep;
      eff_kind = nk;
    end
  end

  assign is_rd = (eff_kind == `K_FETCH1) || (eff_kind == `K_FETCH2) ||
                 (eff_kind == `K_OPRD) || (eff_kind == `K_MEMRD);

  // Byte read in the cycle now ending feeds a write launched at once
  assign wr_byte = (st_q == BUS_T3 && kind_q == `K_MEMRD) ? data_in : byte_q;

  assign push = (st_q == BUS_T3) &&
                ((kind_q == `K_FETCH1) || (kind_q == `K_FETCH2) ||
                 (kind_q == `K_OPRD) || (kind_q == `K_MEMRD));
  assign pop      = rd_valid & rd_ready;
  assign rd_valid = (cnt_q != 2'h0);
  assign rd_data  = buf_mem[rp_q];

  always @* begin
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = cnt_q + 2'h1;
    else if (pop && !push)
      cnt_d = cnt_q - 2'h1;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp_q       <= 1'b0;
      rp_q       <= 1'b0;
      cnt_q      <= 2'h0;
      buf_mem[0] <= 8'h00;
      buf_mem[1] <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
      if (push) begin
        buf_mem[wp_q] <= data_in;
        wp_q          <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q                <= WAIT_CMD;
      op_q                <= 4'h0;
      step_q              <= 4'h0;
      kind_q              <= `K_END;
      pc_q                <= 16'h0000;
      hl_q                <= 16'h0000;
      de_q                <= 16'h0000;
      bc_q                <= 16'h0000;
      acc_q               <= 8'h00;
      g_q                 <= 8'h00;
      port_q              <= 8'h00;
      byte_q              <= 8'h00;
      addr_q              <= 16'h0000;
      data_out_q          <= 8'h00;
      data_oe_q           <= 1'b0;
      read_strobe_n       <= 1'b1;
      store_strobe_n      <= 1'b1;
      memory_request_n    <= 1'b1;
      io_request_n        <= 1'b1;
      opcode_fetch_flag_n <= 1'b1;
      opening_fetch_flag  <= 1'b1;
      halt_n              <= 1'b1;
    end else begin
      halt_n <= 1'b1;
      if (st_q == BUS_T1)
        st_q <= BUS_T2;
      if (st_q == BUS_T2)
        st_q <= BUS_T3;
      if (st_q == BUS_T3) begin
        case (kind_q)
          `K_OPRD: port_q <= data_in;
          `K_MEMRD: begin
            byte_q <= data_in;
            // Copy codes count up on bit 0 set, port codes on bit 0 clear
            hl_q   <= (op_q[3] ^ op_q[0]) ? hl_q + 16'h0001 :
                                            hl_q - 16'h0001;
            if (op_q == `OP_COPY_UP_RPT || op_q == `OP_COPY_DN_RPT) begin
              bc_q <= bc_q - 16'h0001;
            end else if (op_q[3:2] == 2'b10) begin
              bc_q[15:8] <= bc_q[15:8] - 8'h01;
              bc_q[7:0]  <= op_q[0] ? bc_q[7:0] - 8'h01 : bc_q[7:0] + 8'h01;
            end else begin
              bc_q[15:8] <= bc_q[15:8] - 8'h01;
            end
          end
          `K_MEMWR: de_q <= op_q[0] ? de_q + 16'h0001 : de_q - 16'h0001;
          default: ;
        endcase
      end
      if (start) begin
        op_q  <= cmd_op;
        pc_q  <= cmd_pc;
        hl_q  <= cmd_hl;
        de_q  <= cmd_de;
        bc_q  <= cmd_bc;
        acc_q <= cmd_acc;
        g_q   <= cmd_g;
      end
      if (go) begin
        step_q              <= eff_step;
        kind_q              <= eff_kind;
        read_strobe_n       <= 1'b1;
        store_strobe_n      <= 1'b1;
        memory_request_n    <= 1'b1;
        io_request_n        <= 1'b1;
        opcode_fetch_flag_n <= 1'b1;
        opening_fetch_flag  <= 1'b1;
        data_oe_q           <= 1'b0;
        if (eff_kind == `K_END) begin
          st_q <= WAIT_CMD;
        end else if (eff_kind == `K_IDLE) begin
          st_q <= IDLE_STATE;
        end else if (is_rd && cnt_d == `FIFO_DEPTH) begin
          st_q <= HOLD_FIFO;
        end else begin
          st_q <= BUS_T1;
          case (eff_kind)
            `K_FETCH1: begin
              addr_q              <= start ? cmd_pc : pc_q;
              read_strobe_n       <= 1'b0;
              memory_request_n    <= 1'b0;
              opcode_fetch_flag_n <= 1'b0;
              opening_fetch_flag  <= 1'b0;
            end
            `K_FETCH2: begin
              addr_q              <= pc_q + 16'h0001;
              read_strobe_n       <= 1'b0;
              memory_request_n    <= 1'b0;
              opcode_fetch_flag_n <= 1'b0;
            end
            `K_OPRD: begin
              addr_q           <= (op_q == `OP_PORT_IMM_ACC) ?
                                  pc_q + 16'h0001 : pc_q + 16'h0002;
              read_strobe_n    <= 1'b0;
              memory_request_n <= 1'b0;
            end
            `K_MEMRD: begin
              addr_q           <= hl_q;
              read_strobe_n    <= 1'b0;
              memory_request_n <= 1'b0;
            end
            `K_MEMWR: begin
              addr_q           <= de_q;
              data_out_q       <= wr_byte;
              data_oe_q        <= 1'b1;
              store_strobe_n   <= 1'b0;
              memory_request_n <= 1'b0;
            end
            default: begin
              store_strobe_n <= 1'b0;
              io_request_n   <= 1'b0;
              data_oe_q      <= 1'b1;
              case (op_q)
                `OP_PORT_IMM_ACC: begin
                  addr_q     <= {acc_q, port_q};
                  data_out_q <= acc_q;
                end
                `OP_PORT_BC_REG: begin
                  addr_q     <= bc_q;
                  data_out_q <= g_q;
                end
                `OP_PAGE0_WRITE: begin
                  addr_q     <= {`PAGE0_HIGH, port_q};
                  data_out_q <= g_q;
                end
                `OP_PBLK_INC, `OP_PBLK_DEC,
                `OP_PBLK_INC_RPT, `OP_PBLK_DEC_RPT: begin
                  addr_q     <= {`PAGE0_HIGH, bc_q[7:0]};
                  data_out_q <= wr_byte;
                end
                default: begin
                  addr_q     <= bc_q;
                  data_out_q <= wr_byte;
                end
              endcase
            end
          endcase
        end
      end
    end
  end

endmodule // bus_seq

// ---- bus_seq_checker.sv ----
// Assertions on the sequencer bus ports
`timescale 1ns/1ps
module bus_seq_checker (
  input wire        clk_sys,
  input wire        rst_n,
  input wire        cmd_valid,
  input wire        cmd_ready,
  input wire [15:0] cmd_pc,
  input wire [15:0] addr_q,
  input wire        data_oe_q,
  input wire        read_strobe_n,
  input wire        store_strobe_n,
  input wire        memory_request_n,
  input wire        io_request_n,
  input wire        opcode_fetch_flag_n,
  input wire        opening_fetch_flag,
  input wire        halt_n,
  input wire        rd_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  halt_high_a:
    assert property (halt_n) else $error("halt low");
  fetch_shape_a:
    assert property (!opening_fetch_flag |-> !read_strobe_n &&
      !memory_request_n && !opcode_fetch_flag_n && store_strobe_n &&
      io_request_n) else $error("first fetch strobes");
  fetch_len_a:
    assert property ($fell(opening_fetch_flag) |=>
      !opening_fetch_flag [*2] ##1 opening_fetch_flag)
      else $error("first fetch length");
  fetch_two_a:
    assert property (!opcode_fetch_flag_n && opening_fetch_flag |->
      !read_strobe_n && !memory_request_n && store_strobe_n && io_request_n)
      else $error("second fetch strobes");
  mem_write_a:
    assert property (!store_strobe_n && !memory_request_n |->
      io_request_n && read_strobe_n) else $error("memory write strobes");
  io_write_a:
    assert property (!io_request_n |-> memory_request_n && !store_strobe_n
      && read_strobe_n) else $error("port write strobes");
  write_len_a:
    assert property ($fell(store_strobe_n) |=> (!store_strobe_n &&
      $stable(addr_q)) [*2] ##1 store_strobe_n) else $error("write length");
  bus_float_a:
    assert property (data_oe_q == !store_strobe_n) else $error("data drive");
  take_fetch_a:
    assert property (cmd_valid && cmd_ready && !rd_valid |=>
      !opening_fetch_flag && addr_q == $past(cmd_pc))
      else $error("fetch not at start address");
endmodule // bus_seq_checker

bind bus_seq bus_seq_checker bus_seq_checker_i (.clk_sys(clk_sys),
  .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_pc(cmd_pc), .addr_q(addr_q), .data_oe_q(data_oe_q),
  .read_strobe_n(read_strobe_n), .store_strobe_n(store_strobe_n),
  .memory_request_n(memory_request_n), .io_request_n(io_request_n),
  .opcode_fetch_flag_n(opcode_fetch_flag_n), .rd_valid(rd_valid),
  .opening_fetch_flag(opening_fetch_flag), .halt_n(halt_n));

// ---- bus_seq_defs.vh ----
// Constants for the external bus machine-cycle sequencer
`ifndef BUS_SEQ_DEFS_VH
`define BUS_SEQ_DEFS_VH

// Instruction codes presented on cmd_op
`define OP_IDLE          4'h0
`define OP_NEGATE        4'h1
`define OP_MULTIPLY      4'h2
`define OP_COPY_UP_RPT   4'h3
`define OP_COPY_DN_RPT   4'h4
`define OP_PORT_IMM_ACC  4'h5
`define OP_PORT_BC_REG   4'h6
`define OP_PAGE0_WRITE   4'h7
`define OP_PBLK_INC      4'h8
`define OP_PBLK_DEC      4'h9
`define OP_PBLK_INC_RPT  4'hA
`define OP_PBLK_DEC_RPT  4'hB
`define OP_PCOPY_INC     4'hC
`define OP_PCOPY_DEC     4'hD
`define OP_PCOPY_INC_RPT 4'hE
`define OP_PCOPY_DEC_RPT 4'hF

// Machine cycle kinds
`define K_FETCH1 3'h0
`define K_FETCH2 3'h1
`define K_OPRD   3'h2
`define K_MEMRD  3'h3
`define K_MEMWR  3'h4
`define K_IOWR   3'h5
`define K_IDLE   3'h6
`define K_END    3'h7

// Step, buffer and page figures
`define MULT_LAST_STEP 4'hC
`define FIFO_DEPTH     2'h2
`define PAGE0_HIGH     8'h00

`endif
